/* File: rtl/mem_map_pkg.sv */
// Constants and carrier types for the data memory and register page block
package mem_map_pkg;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] PAGE_IRQ = 8'h00;
    localparam logic [7:0] PAGE_CAN = 8'h0C;
    localparam logic [7:0] PAGE_CFG = 8'h0F;
    localparam logic [7:0] LOWER_TOP = 8'h7F;
    localparam logic [7:0] BIT_BASE = 8'h20;
    localparam int BANK_LSB = 3;
    localparam int AUTOPAGE_BIT = 0;
    localparam logic AUTOPAGE_RESET = 1'b1;
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam logic [7:0] REG_SP = 8'h81;
    localparam logic [7:0] REG_PAGE_CTRL = 8'h84;
    localparam logic [7:0] REG_STK_MID = 8'h85;
    localparam logic [7:0] REG_STK_BOT = 8'h86;
    localparam logic [7:0] REG_FLASH_CTRL = 8'h8F;
    localparam logic [7:0] REG_PAGE_SEL = 8'hA7;
    localparam logic [7:0] REG_PSW = 8'hD0;
    localparam logic [15:0] LOCK_64K = 16'hFBFF;
    localparam logic [15:0] LOCK_32K = 16'h7FFF;
    localparam logic [15:0] RSVD_ABOVE_64K = 16'hFDFF;
    localparam logic [15:0] TOP_32K = 16'h7FFF;
    localparam logic [15:0] ONCHIP_EXTERNAL_RAM_TOP = 16'h0FFF;
    localparam int AXI_AW = 10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {OP_NONE, OP_READ, OP_WRITE, OP_PUSH, OP_POP} op_t;
    typedef enum logic [1:0] {TGT_RAM, TGT_LOCAL, TGT_EXT} tgt_t;

    typedef struct packed {
        op_t op;
        logic indirect;
        logic bit_op;
        logic [7:0] addr;
        logic [7:0] wdata;
    } core_req_t;

    typedef struct packed {
        logic rd;
        logic we;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_bus_t;

    typedef struct packed {
        logic flash_rd;
        logic flash_wr;
        logic onchip_external_ram_sel;
        logic lock_hit;
        logic reserved_hit;
    } code_info_t;
endpackage

/* File: rtl/ram_256.sv */
// Internal data RAM with registered read data
`timescale 1ns/1ps
`default_nettype none
module ram_256 import mem_map_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [256];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= mem[addr];
        end
    end
endmodule
`default_nettype wire

/* File: rtl/page_stack.sv */
// Three-level register page stack with its auto paging enable
`timescale 1ns/1ps
`default_nettype none
module page_stack import mem_map_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic push,
    input wire logic pop,
    input wire logic [7:0] push_page,
    input wire logic wr_cur,
    input wire logic wr_mid,
    input wire logic wr_bot,
    input wire logic wr_ctrl,
    input wire logic [7:0] wr_data,
    output logic [7:0] cur,
    output logic [7:0] mid,
    output logic [7:0] bot,
    output logic en
);
    // A hardware shift in the same cycle as a software write wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= PAGE_RESET; // [RQ24]
            mid <= PAGE_RESET;
            bot <= PAGE_RESET;
            en <= AUTOPAGE_RESET; // [RQ18] [RQ23]
        end else begin
            if (wr_ctrl) begin
                en <= wr_data[AUTOPAGE_BIT]; // [RQ23]
            end
            if (en && push) begin // [RQ22] [RQ25]
                bot <= mid; // [RQ13]
                mid <= cur;
                cur <= push_page;
            end else if (en && pop) begin
                cur <= mid; // [RQ15]
                mid <= bot;
                bot <= PAGE_RESET;
            end else begin
                // Plain stores, no shift [RQ16] [RQ17]
                if (wr_cur) cur <= wr_data;
                if (wr_mid) mid <= wr_data;
                if (wr_bot) bot <= wr_data;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/data_memory_sfr_paging.sv */
// Data memory address decode, stack pointer, register paging and AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none
// Operation
// RQ1: Lower 128 bytes reachable direct and indirect
// RQ2: Four register banks chosen by status bits
// RQ3: Indirect uses first two bank registers
// RQ4: Bytes 0x20-0x2F form bit addresses 0-0x7F
// RQ5: Bit or byte chosen by operand type
// RQ6: Above 0x7F: direct to registers, indirect RAM
// RQ7: Push writes at pointer plus one, increments
// RQ8: Stack pointer resets to 0x07
// RQ9: Registers ending 0x0/0x8 are bit addressable
// RQ10: Software avoids unoccupied register addresses
// RQ11: 256 pages; only 0x0, 0xC, 0xF populated
// RQ12: Software selects page, then direct move
// RQ13: Interrupt entry shifts page stack down
// RQ14: Interrupt loads page 0x00, CAN 0x0C
// RQ15: Return pops stack; bottom becomes 0x00
// RQ16: Software stack writes never push or pop
// RQ17: Rewritten stack levels restore on return
// RQ18: Auto paging enabled from reset
// RQ19: All-page registers ignore current page
// RQ20: Code reads flash; data moves hit ONCHIP_EXTERNAL_RAM
// RQ21: Lock byte and reserved flash addresses
// RQ22: Paging disabled: no switch, no stack
// RQ23: Enable is control bit 0, others zero
// RQ24: Current page register at 0xA7, reset zero
// RQ25: Stack shifts in the vectoring cycle
module data_memory_sfr_paging import mem_map_pkg::*; #(
    parameter bit PART_64K = 1'b1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic core_req_valid,
    input wire core_req_t core_req,
    output var logic core_busy,
    output var logic rsp_valid,
    output var logic [7:0] rsp_data,
    output var sfr_bus_t sfr_bus,
    input wire logic [7:0] sfr_rdata,
    input wire logic irq_enter,
    input wire logic irq_is_can,
    input wire logic irq_return,
    output logic [7:0] current_page_select,
    output logic auto_paging_enable,
    input wire logic code_valid,
    input wire logic code_movc,
    input wire logic code_write,
    input wire logic [15:0] code_addr,
    output var logic code_info_valid,
    output var code_info_t code_info,
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output var logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp
);
    typedef enum logic [1:0] {S_IDLE, S_PTR, S_ACC, S_DATA} state_t;

    state_t state_r, state_nxt;
    core_req_t req_r;
    tgt_t tgt_r, tgt_nxt;
    logic [7:0] ea_r, ea_nxt, sp_r, psw_r, flash_ctrl_r;
    logic [2:0] bpos_r, bpos_nxt;
    logic [AXI_AW-1:0] aw_addr_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic [7:0] stk_mid, stk_bot;
    logic [7:0] ram_rdata;

    // Register file view shared by the core and the bus: {hit, data}
    function automatic logic [8:0] reg_rd(input logic [7:0] idx);
        logic [8:0] r;
        r = 9'h000;
        unique case (idx)
            REG_SP: r = {1'b1, sp_r};
            REG_PSW: r = {1'b1, psw_r};
            REG_PAGE_SEL: r = {1'b1, current_page_select};
            REG_PAGE_CTRL: r = {1'b1, 7'h00, auto_paging_enable}; // [RQ23]
            REG_STK_MID: r = {1'b1, stk_mid};
            REG_STK_BOT: r = {1'b1, stk_bot};
            REG_FLASH_CTRL: r = {1'b1, 7'h00, flash_ctrl_r[0]};
            default: r = 9'h000;
        endcase
        return r;
    endfunction

    // Page-independent registers answer on every page
    function automatic logic page_ok(input logic [7:0] idx, input logic [7:0] page);
        return (idx == REG_SP) || (idx == REG_PSW) || (idx == REG_PAGE_SEL) // [RQ19]
            || (page == PAGE_CFG);
    endfunction

    function automatic logic [7:0] axi_idx(input logic [AXI_AW-1:0] a);
        return a[9:2];
    endfunction

    // Request decode in the idle state
    wire [1:0] bank = psw_r[BANK_LSB +: 2]; // [RQ2]
    wire [7:0] ptr_addr = {3'b000, bank, 2'b00, core_req.addr[0]}; // [RQ3]
    wire is_push = core_req.op == OP_PUSH;
    wire is_pop = core_req.op == OP_POP;
    wire [7:0] bit_byte = core_req.addr[7] ? {core_req.addr[7:3], 3'b000} // [RQ9]
                                           : BIT_BASE + {4'h0, core_req.addr[6:3]}; // [RQ4]
    wire take = (state_r == S_IDLE) && core_req_valid;
    wire need_ptr = core_req.indirect && !is_push && !is_pop;
    wire [7:0] sp_plus = sp_r + 8'h01;

    // Access decode
    wire stack_or_ind = req_r.indirect || (req_r.op == OP_PUSH) || (req_r.op == OP_POP);
    wire [8:0] loc_rd = reg_rd(ea_r);
    wire loc_hit = loc_rd[8] && page_ok(ea_r, current_page_select);
    wire wr_op = (req_r.op == OP_WRITE) || (req_r.op == OP_PUSH);
    wire byte_wr = (req_r.op == OP_WRITE) && !req_r.bit_op;
    wire [7:0] rd_val = (tgt_r == TGT_RAM) ? ram_rdata
                      : (tgt_r == TGT_LOCAL) ? loc_rd[7:0] : sfr_rdata;
    wire [7:0] bmask = 8'h01 << bpos_r;
    wire [7:0] merged = req_r.bit_op ? ((rd_val & ~bmask) | (req_r.wdata[0] ? bmask : 8'h00))
                                     : req_r.wdata; // [RQ5]
    wire in_data = state_r == S_DATA;
    wire core_loc_we = in_data && wr_op && (tgt_r == TGT_LOCAL);
    wire ram_we = in_data && wr_op && (tgt_r == TGT_RAM);
    wire [7:0] ram_addr = (state_r == S_IDLE) ? ptr_addr : ea_r;

    // Bus write waits while the core owns the data phase
    wire axi_we = !s_axi_awready && !s_axi_wready && !s_axi_bvalid && !in_data;
    wire [7:0] aw_idx = axi_idx(aw_addr_r);
    wire [8:0] aw_rd = reg_rd(aw_idx);
    wire axi_w_ok = aw_rd[8] && (aw_addr_r[1:0] == 2'b00);
    wire loc_we = core_loc_we || (axi_we && axi_w_ok && wstrb0_r);
    wire [7:0] loc_idx = core_loc_we ? ea_r : aw_idx;
    wire [7:0] loc_data = core_loc_we ? merged : wdata_r;
    wire [8:0] ar_rd = reg_rd(axi_idx(s_axi_araddr));
    wire ar_ok = ar_rd[8] && (s_axi_araddr[1:0] == 2'b00);
    wire [7:0] irq_page = irq_is_can ? PAGE_CAN : PAGE_IRQ; // [RQ14]

    always_comb begin
        state_nxt = state_r;
        ea_nxt = ea_r;
        bpos_nxt = bpos_r;
        tgt_nxt = tgt_r;
        unique case (state_r)
            S_IDLE: begin
                if (take) begin
                    state_nxt = need_ptr ? S_PTR : S_ACC;
                    bpos_nxt = core_req.addr[2:0];
                    if (is_push) ea_nxt = sp_plus; // [RQ7]
                    else if (is_pop) ea_nxt = sp_r;
                    else if (core_req.bit_op) ea_nxt = bit_byte; // [RQ5]
                    else ea_nxt = core_req.addr; // [RQ1]
                end
            end
            S_PTR: begin
                ea_nxt = ram_rdata; // [RQ3]
                state_nxt = S_ACC;
            end
            S_ACC: begin
                // Above 0x7F the addressing mode picks the space [RQ6]
                if ((ea_r <= LOWER_TOP) || stack_or_ind) tgt_nxt = TGT_RAM; // [RQ1] [RQ8]
                else if (loc_hit) tgt_nxt = TGT_LOCAL;
                else tgt_nxt = TGT_EXT; // [RQ11] [RQ12]
                state_nxt = S_DATA;
            end
            S_DATA: state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= S_IDLE;
            req_r <= '0;
            ea_r <= 8'h00;
            bpos_r <= 3'h0;
            tgt_r <= TGT_RAM;
            core_busy <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ea_r <= ea_nxt;
            bpos_r <= bpos_nxt;
            tgt_r <= tgt_nxt;
            core_busy <= state_nxt != S_IDLE;
            if (take) req_r <= core_req;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            sfr_bus <= '0;
        end else begin
            rsp_valid <= in_data;
            if (in_data) rsp_data <= req_r.bit_op ? {7'h00, rd_val[bpos_r]} : rd_val;
            sfr_bus.rd <= (state_r == S_ACC) && (tgt_nxt == TGT_EXT) && !byte_wr;
            sfr_bus.we <= in_data && wr_op && (tgt_r == TGT_EXT);
            if (state_r == S_ACC) begin
                sfr_bus.addr <= ea_r;
                sfr_bus.page <= current_page_select; // [RQ12]
            end
            if (in_data) sfr_bus.wdata <= merged;
        end
    end

    // Stack pointer, status word and flash write steering
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sp_r <= SP_RESET; // [RQ8]
            psw_r <= PSW_RESET;
            flash_ctrl_r <= 8'h00;
        end else begin
            if (in_data && (req_r.op == OP_PUSH)) sp_r <= sp_plus; // [RQ7]
            else if (in_data && (req_r.op == OP_POP)) sp_r <= sp_r - 8'h01;
            else if (loc_we && (loc_idx == REG_SP)) sp_r <= loc_data;
            if (loc_we && (loc_idx == REG_PSW)) psw_r <= loc_data; // [RQ2]
            if (loc_we && (loc_idx == REG_FLASH_CTRL)) flash_ctrl_r <= {7'h00, loc_data[0]};
        end
    end

    ram_256 u_ram (
        .clk(clk),
        .arst_n(arst_n),
        .addr(ram_addr),
        .we(ram_we),
        .wdata(merged),
        .rdata(ram_rdata)
    );

    page_stack u_stack (
        .clk(clk),
        .arst_n(arst_n),
        .push(irq_enter), // [RQ13] [RQ25]
        .pop(irq_return), // [RQ15]
        .push_page(irq_page),
        .wr_cur(loc_we && (loc_idx == REG_PAGE_SEL)), // [RQ24]
        .wr_mid(loc_we && (loc_idx == REG_STK_MID)), // [RQ17]
        .wr_bot(loc_we && (loc_idx == REG_STK_BOT)),
        .wr_ctrl(loc_we && (loc_idx == REG_PAGE_CTRL)),
        .wr_data(loc_data),
        .cur(current_page_select),
        .mid(stk_mid),
        .bot(stk_bot),
        .en(auto_paging_enable)
    );

    // Program memory decode: code reads hit flash, data moves up to 0x0FFF hit ONCHIP_EXTERNAL_RAM unless flash_ctrl_r[0] steers writes to flash
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            code_info_valid <= 1'b0;
            code_info <= '0;
        end else begin
            code_info_valid <= code_valid;
            if (code_valid) begin
                code_info.flash_rd <= code_movc; // [RQ20]
                code_info.flash_wr <= !code_movc && code_write && flash_ctrl_r[0];
                code_info.onchip_external_ram_sel <= !code_movc && !(code_write && flash_ctrl_r[0])
                                      && (code_addr <= ONCHIP_EXTERNAL_RAM_TOP);
                code_info.lock_hit <= code_addr == (PART_64K ? LOCK_64K : LOCK_32K); // [RQ21]
                code_info.reserved_hit <= PART_64K ? (code_addr > RSVD_ABOVE_64K)
                                                   : (code_addr > TOP_32K);
            end
        end
    end

    // AXI4-Lite slave, one write and one read in flight
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr_r <= '0;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (axi_we) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= axi_w_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= ar_ok ? {24'h000000, ar_rd[7:0]} : 32'h0000_0000;
            s_axi_rresp <= ar_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    push_addr_a: assert property ((state_r == S_ACC && req_r.op == OP_PUSH) // [RQ7]
        |-> ea_r == sp_r + 8'h01 ##2 sp_r == $past(sp_r) + 8'h01)
        else $error("push address or pointer step wrong");
    bank_ptr_a: assert property ((take && need_ptr) // [RQ3]
        |-> ram_addr == {3'b000, psw_r[4:3], 2'b00, core_req.addr[0]})
        else $error("index register not in active bank");
    bit_map_a: assert property ((take && core_req.bit_op && !core_req.addr[7]) // [RQ4]
        |=> ea_r == 8'h20 + {4'h0, $past(core_req.addr[6:3])})
        else $error("bit address maps to wrong byte");
    upper_ram_a: assert property ((state_r == S_ACC && ea_r > 8'h7F && req_r.indirect) // [RQ6]
        |=> tgt_r == TGT_RAM)
        else $error("indirect upper access left RAM");
    direct_sfr_a: assert property ((state_r == S_ACC && ea_r > 8'h7F && !stack_or_ind) // [RQ6]
        |=> tgt_r != TGT_RAM && $past(sfr_bus.rd) == 1'b0)
        else $error("direct upper access went to RAM");
    irq_page_a: assert property ((irq_enter && auto_paging_enable) // [RQ14]
        |=> current_page_select == ($past(irq_is_can) ? 8'h0C : 8'h00))
        else $error("wrong page loaded on interrupt");
    irq_push_a: assert property ((irq_enter && auto_paging_enable) // [RQ13]
        |=> stk_mid == $past(current_page_select) && stk_bot == $past(stk_mid))
        else $error("page stack push wrong");
    reti_pop_a: assert property ((irq_return && !irq_enter && auto_paging_enable) // [RQ15]
        |=> current_page_select == $past(stk_mid) && stk_bot == 8'h00)
        else $error("page stack pop wrong");
    no_auto_a: assert property ((irq_enter && !auto_paging_enable && !loc_we) // [RQ22]
        |=> $stable(current_page_select) && $stable(stk_mid) && $stable(stk_bot))
        else $error("page changed with auto paging off");
    lock_byte_a: assert property ((code_valid && code_addr == (PART_64K ? 16'hFBFF : 16'h7FFF))
        |=> code_info.lock_hit && code_info_valid) // [RQ21]
        else $error("lock byte not flagged");
endmodule
`default_nettype wire

/* File: tb/sfr_pages_model.sv */
// Peripheral register pages model on the far side of the register bus
`timescale 1ns/1ps
`default_nettype none
module sfr_pages_model import mem_map_pkg::*; (
    input wire logic clk,
    input wire sfr_bus_t bus,
    output logic [7:0] rdata
);
    logic [7:0] regs [0:511];
    logic [7:0] last_r;
    logic [8:0] k;
    wire [8:0] idx = {bus.page[3], bus.page[0], bus.addr[6:0]};
    // Pages 0x00, 0x0C, 0x0F start with distinct patterns, so a wrong page shows
    initial begin
        last_r = 8'h00;
        for (int i = 0; i < 512; i++) begin
            k = 9'(i);
            regs[i] = {1'b1, k[6:0]} ^ {k[8:7], 6'h00};
        end
    end
    // Undriven read data is the inverse of the last byte, never a stale copy
    assign rdata = bus.rd ? regs[idx] : ~last_r;
    always @(posedge clk) begin
        if (bus.we) regs[idx] <= bus.wdata;
        if (bus.rd) last_r <= regs[idx];
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for data memory decode, page stack and register access
`timescale 1ns/1ps
`default_nettype none
module testbench import mem_map_pkg::*;;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic core_req_valid = 1'b0;
    core_req_t core_req = '0;
    logic core_busy, rsp_valid, auto_paging_enable, code_info_valid;
    logic [7:0] rsp_data, sfr_rdata, current_page_select, q;
    sfr_bus_t sfr_bus;
    code_info_t code_info;
    logic irq_enter = 1'b0, irq_is_can = 1'b0, irq_return = 1'b0;
    logic code_valid = 1'b0, code_movc = 1'b0, code_write = 1'b0;
    logic [15:0] code_addr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int num_errors = 0, checked = 0, cycles = 0;

    data_memory_sfr_paging u_data_memory_sfr_paging (.clk, .arst_n, .core_req_valid,
        .core_req, .core_busy, .rsp_valid, .rsp_data, .sfr_bus, .sfr_rdata, .irq_enter,
        .irq_is_can, .irq_return, .current_page_select, .auto_paging_enable, .code_valid,
        .code_movc, .code_write, .code_addr, .code_info_valid, .code_info, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp);
    sfr_pages_model u_sfr_pages_model (.clk(clk), .bus(sfr_bus), .rdata(sfr_rdata));

    always #2.5 clk = ~clk;

    task complete_run;
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic core(input op_t op, input logic ind, input logic bo, input logic [7:0] a,
                        input logic [7:0] wd);
        int n;
        @(posedge clk);
        core_req_valid <= 1'b1;
        core_req <= '{op: op, indirect: ind, bit_op: bo, addr: a, wdata: wd};
        @(posedge clk);
        core_req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (rsp_valid !== 1'b1 && n < 20);
        q = rsp_data;
        chk("core answer", 32'h1, 32'(rsp_valid));
    endtask

    task wr(input logic [7:0] a, input logic [7:0] wd);
        core(OP_WRITE, 1'b0, 1'b0, a, wd);
    endtask

    task rd_exp(input logic ind, input logic bo, input logic [7:0] a, input logic [7:0] e);
        core(OP_READ, ind, bo, a, 8'h00);
        chk("core read", 32'(e), 32'(q));
    endtask

    task automatic axi_wr(input logic [9:0] a, input logic [31:0] wd, input logic [1:0] er);
        int n;
        @(posedge clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= wd;
        s_axi_wstrb <= 4'hF;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 30);
        s_axi_bready <= 1'b0;
        chk("write response", 32'(er), 32'(s_axi_bresp));
    endtask

    task automatic axi_rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 30);
        s_axi_rready <= 1'b0;
        chk("read response", 32'(er), 32'(s_axi_rresp));
        chk("read data", e, s_axi_rdata);
    endtask

    // The page check lands one edge after the pulse: the handler sees it at once
    task irq(input logic e, input logic c, input logic rt, input logic [7:0] page);
        @(posedge clk);
        irq_enter <= e;
        irq_is_can <= c;
        irq_return <= rt;
        @(posedge clk);
        irq_enter <= 1'b0;
        irq_is_can <= 1'b0;
        irq_return <= 1'b0;
        #1;
        chk("current page", 32'(page), 32'(current_page_select));
    endtask

    task code(input logic mv, input logic wrt, input logic [15:0] a, input code_info_t e);
        @(posedge clk);
        code_valid <= 1'b1;
        code_movc <= mv;
        code_write <= wrt;
        code_addr <= a;
        @(posedge clk);
        code_valid <= 1'b0;
        #1;
        chk("code valid", 32'h1, 32'(code_info_valid));
        chk("code info", 32'(e), 32'(code_info));
    endtask

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        chk("page reset", 32'(PAGE_RESET), 32'(current_page_select));
        chk("paging enable reset", 32'h1, 32'(auto_paging_enable));
        rd_exp(1'b0, 1'b0, REG_SP, 8'h07);
        axi_rd(10'h210, 32'h1, RESP_OKAY);
        axi_rd(10'h000, 32'h0, RESP_SLVERR);
        axi_wr(10'h211, 32'h0, RESP_SLVERR);
        axi_rd(10'h210, 32'h1, RESP_OKAY);
        axi_wr(10'h210, 32'hFE, RESP_OKAY);
        axi_rd(10'h210, 32'h0, RESP_OKAY);
        irq(1'b1, 1'b1, 1'b0, 8'h00);
        axi_wr(10'h210, 32'h1, RESP_OKAY);
        $display("test reset and enable done");
        core(OP_PUSH, 1'b0, 1'b0, 8'h00, 8'h5A);
        rd_exp(1'b0, 1'b0, REG_SP, 8'h08);
        rd_exp(1'b0, 1'b0, 8'h08, 8'h5A);
        core(OP_POP, 1'b0, 1'b0, 8'h00, 8'h00);
        chk("pop data", 32'h5A, 32'(q));
        rd_exp(1'b0, 1'b0, REG_SP, 8'h07);
        $display("test stack done");
        for (int b = 0; b < 4; b++) begin
            wr(8'(b * 8), 8'h40 + 8'(b));
            wr(8'h40 + 8'(b), 8'hC0 + 8'(b));
            wr(REG_PSW, 8'(b << BANK_LSB));
            rd_exp(1'b1, 1'b0, 8'h00, 8'hC0 + 8'(b));
        end
        wr(8'h19, 8'h90);
        core(OP_WRITE, 1'b1, 1'b0, 8'h01, 8'hAB);
        rd_exp(1'b0, 1'b0, 8'h90, 8'h90);
        rd_exp(1'b1, 1'b0, 8'h01, 8'hAB);
        $display("test banks done");
        wr(8'h22, 8'h00);
        wr(8'h2F, 8'h00);
        core(OP_WRITE, 1'b0, 1'b1, 8'h13, 8'h01);
        core(OP_WRITE, 1'b0, 1'b1, 8'h7F, 8'h01);
        rd_exp(1'b0, 1'b0, 8'h22, 8'h08);
        rd_exp(1'b0, 1'b0, 8'h2F, 8'h80);
        rd_exp(1'b0, 1'b1, 8'h13, 8'h01);
        $display("test bits done");
        axi_wr(10'h29C, 32'h0C, RESP_OKAY);
        rd_exp(1'b0, 1'b0, 8'h90, 8'h10);
        rd_exp(1'b0, 1'b0, REG_SP, 8'h07);
        axi_wr(10'h29C, 32'h03, RESP_OKAY);
        irq(1'b1, 1'b1, 1'b0, PAGE_CAN);
        axi_rd(10'h214, 32'h03, RESP_OKAY);
        irq(1'b1, 1'b0, 1'b0, PAGE_IRQ);
        axi_rd(10'h214, 32'h0C, RESP_OKAY);
        axi_rd(10'h218, 32'h03, RESP_OKAY);
        irq(1'b0, 1'b0, 1'b1, PAGE_CAN);
        axi_rd(10'h214, 32'h03, RESP_OKAY);
        axi_rd(10'h218, 32'h00, RESP_OKAY);
        axi_wr(10'h214, 32'h0F, RESP_OKAY);
        chk("page after stack write", 32'h0C, 32'(current_page_select));
        axi_rd(10'h218, 32'h00, RESP_OKAY);
        irq(1'b0, 1'b0, 1'b1, PAGE_CFG);
        $display("test page stack done");
        code(1'b1, 1'b0, LOCK_64K, 5'b10010);
        code(1'b1, 1'b0, RSVD_ABOVE_64K, 5'b10000);
        code(1'b1, 1'b0, 16'hFE00, 5'b10001);
        code(1'b0, 1'b0, 16'h0100, 5'b00100);
        axi_wr(10'h23C, 32'h1, RESP_OKAY);
        code(1'b0, 1'b1, 16'h0100, 5'b01000);
        $display("test code decode done");
        complete_run();
    end
endmodule
`default_nettype wire
